// [vic_src_regs.svh]
// Behaviour
// - controller clock is free-running; no gating or power setting alters it
// - normal or fast request assertion drives the wake output for an idle core
// - global mask keeps both request lines high while wake still follows events
// - source 0 is the fast request pin and feeds only the fast line
// - source 1 is the OR of all system peripheral interrupt lines
// - sources 2 to 31 come from peripheral or external interrupt inputs
// - source number equals peripheral identifier and its clock-gate bit position
// - internal sources select level or edge; their polarity is fixed active high
// - external sources select high level, low level, rising or falling edge
// - enable and disable commands change mask in one write; mask is readable
// - a disabled source takes no part in prioritisation or servicing
// - set and clear commands force or remove pending of edge sources
// - set and clear commands aimed at level sources are ignored
// - normal vector read clears edge memory of the new current source only
// - fast-forced sources are spared the normal vector read auto clear
// - fast vector read clears source 0
// - pending status shows activity of every source, masked or not
// - current number status returns the source now being serviced
// - core line status returns present levels of both request outputs
// - external sources have equal latency whatever path they arrive by
// - each source has priority 0 to 7, 7 highest
// - equal top priority at vector read picks lowest source number
// - a normal vector read deasserts the normal request line
// - eight-entry stack saves number and level per normal vector read; end-of-service pops
`ifndef VIC_SRC_REGS_SVH
`define VIC_SRC_REGS_SVH
`define VIC_NSRC 32
`define VIC_STACK 8
`define VIC_OFS_SMR_LAST 12'h07c
`define VIC_OFS_IVR 12'h100
`define VIC_OFS_FVR 12'h104
`define VIC_OFS_ISR 12'h108
`define VIC_OFS_IPR 12'h10c
`define VIC_OFS_IMR 12'h110
`define VIC_OFS_CISR 12'h114
`define VIC_OFS_IECR 12'h120
`define VIC_OFS_IDCR 12'h124
`define VIC_OFS_ICCR 12'h128
`define VIC_OFS_ISCR 12'h12c
`define VIC_OFS_EOICR 12'h130
`define VIC_OFS_GMASK 12'h138
`define VIC_OFS_FFR 12'h140
`define VIC_SMR_PRIO_LSB 0
`define VIC_SMR_TYPE_LSB 5
`define VIC_GMASK_BIT 1
`define VIC_SPURIOUS 32'h0000_00ff
`define VIC_FAST_VECTOR 32'h0000_0000
`endif

// [vic_src_pkg.sv]
`include "vic_src_regs.svh"
package vic_src_pkg;
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic edgeMem;
  } src_state_t;

  typedef struct packed {
    logic [`VIC_NSRC-1:0][2:0] prio;
    logic [`VIC_NSRC-1:0][1:0] trig;
    logic [`VIC_NSRC-1:0] mask;
    logic [`VIC_NSRC-1:0] ffr;
    logic gmask;
    logic [`VIC_STACK-1:0][4:0] stkNum;
    logic [`VIC_STACK-1:0][2:0] stkLvl;
    logic [3:0] sp;
    logic normalN;
    logic fastN;
    logic wake;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } vic_state_t;
endpackage

// [vic_src_stage.sv]
`timescale 1ns/10ps
`default_nettype none
module vic_src_stage
  import vic_src_pkg::*;
#(
  parameter bit IS_EXT = 1'b0
)(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic rawIn,
  input wire logic [1:0] trigType,
  input wire logic setCmd,
  input wire logic clrCmd,
  input wire logic autoClr,
  output logic pending
);
  src_state_t q;
  src_state_t d;
  logic sample;
  logic polHigh;
  logic active;
  logic wasActive;
  logic edgeMode;

  always_comb
  begin
    d = q;
    d.sync1 = rawIn;
    d.sync2 = q.sync1;
    sample = IS_EXT ? q.sync2 : rawIn;
    polHigh = IS_EXT ? trigType[1] : 1'b1;
    edgeMode = trigType[0];
    active = (sample == polHigh);
    wasActive = (q.prev == polHigh);
    d.prev = sample;
    if (!edgeMode)
    begin
      d.edgeMem = 1'b0;
    end
    else if ((active && !wasActive) || setCmd)
    begin
      d.edgeMem = 1'b1;
    end
    else if (clrCmd || autoClr)
    begin
      d.edgeMem = 1'b0;
    end
    pending = edgeMode ? q.edgeMem : active;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end
endmodule // vic_src_stage
`default_nettype wire

// [vic_source_control.sv]
`timescale 1ns/10ps
`default_nettype none
module vic_source_control
  import vic_src_pkg::*;
#(
  parameter int NSYS = 4,
  parameter logic [`VIC_NSRC-1:0] EXT_SRC = 32'h0000_0001
)(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fastRequestPin,
  input wire logic [NSYS-1:0] systemSource,
  input wire logic [`VIC_NSRC-1:2] peripheralSource,
  output logic normalRequestN,
  output logic fastRequestN,
  output logic wake
);
  // ----------------------------------------
  // state and wiring
  // ----------------------------------------
  vic_state_t q;
  vic_state_t d;
  logic [`VIC_NSRC-1:0] rawIn;
  logic [`VIC_NSRC-1:0] pending;
  logic [`VIC_NSRC-1:0] setCmd;
  logic [`VIC_NSRC-1:0] clrCmd;
  logic [`VIC_NSRC-1:0] autoClr;
  logic [`VIC_NSRC-1:0] cand;
  logic access;
  logic ivrRead;
  logic bestValid;
  logic [4:0] bestNum;
  logic [2:0] bestLvl;
  logic curValid;
  logic [2:0] topIdx;
  logic [2:0] curLvl;
  logic [4:0] curNum;
  logic higher;
  logic irqReq;
  logic fiqReq;
  logic [4:0] smrIdx;

  // ----------------------------------------
  // source wiring
  // ----------------------------------------
  assign rawIn[0] = fastRequestPin;
  assign rawIn[1] = |systemSource;
  assign rawIn[`VIC_NSRC-1:2] = peripheralSource;
  assign smrIdx = paddr[6:2];

  // ----------------------------------------
  // per-source input stages
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `VIC_NSRC; gi++)
    begin : gSrc
      vic_src_stage #(
        .IS_EXT(EXT_SRC[gi])
      ) uStage (
        .clk_sys(clk_sys),
        .rst(rst),
        .rawIn(rawIn[gi]),
        .trigType(q.trig[gi]),
        .setCmd(setCmd[gi]),
        .clrCmd(clrCmd[gi]),
        .autoClr(autoClr[gi]),
        .pending(pending[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // priority resolver
  // ----------------------------------------
  always_comb
  begin
    bestValid = 1'b0;
    bestNum = 5'h00;
    bestLvl = 3'h0;
    for (int i = `VIC_NSRC - 1; i >= 0; i--)
    begin
      if (cand[i] && (!bestValid || q.prio[i] >= bestLvl))
      begin
        bestValid = 1'b1;
        bestNum = 5'(i);
        bestLvl = q.prio[i];
      end
    end
  end

  // ----------------------------------------
  // stack top and preemption
  // ----------------------------------------
  always_comb
  begin
    curValid = (q.sp != 4'h0);
    topIdx = 3'(q.sp - 4'h1);
    curLvl = q.stkLvl[topIdx];
    curNum = curValid ? q.stkNum[topIdx] : 5'h00;
    higher = bestValid && (!curValid || bestLvl > curLvl);
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    d = q;
    setCmd = '0;
    clrCmd = '0;
    autoClr = '0;
    ivrRead = 1'b0;
    cand = pending & q.mask & ~q.ffr & ~32'h0000_0001;
    access = psel && penable && !q.pready;
    d.pready = access;
    d.pslverr = 1'b0;
    if (access)
    begin
      d.prdata = 32'h0000_0000;
      if (paddr <= `VIC_OFS_SMR_LAST && paddr[1:0] == 2'b00)
      begin
        if (pwrite)
        begin
          d.prio[smrIdx] = pwdata[`VIC_SMR_PRIO_LSB+:3];
          d.trig[smrIdx] = pwdata[`VIC_SMR_TYPE_LSB+:2];
        end
        else
        begin
          d.prdata[`VIC_SMR_PRIO_LSB+:3] = q.prio[smrIdx];
          d.prdata[`VIC_SMR_TYPE_LSB+:2] = q.trig[smrIdx];
        end
      end
      else
      begin
        case (paddr)
          `VIC_OFS_IVR:
          begin
            if (!pwrite)
            begin
              ivrRead = 1'b1;
              if (bestValid)
              begin
                d.prdata = {27'h0, bestNum};
                autoClr[bestNum] = !q.ffr[bestNum];
                if (q.sp != 4'(`VIC_STACK))
                begin
                  d.stkNum[q.sp[2:0]] = bestNum;
                  d.stkLvl[q.sp[2:0]] = bestLvl;
                  d.sp = q.sp + 4'h1;
                end
              end
              else
              begin
                d.prdata = `VIC_SPURIOUS;
              end
            end
          end
          `VIC_OFS_FVR:
          begin
            if (!pwrite)
            begin
              d.prdata = `VIC_FAST_VECTOR;
              autoClr[0] = 1'b1;
            end
          end
          `VIC_OFS_ISR:
          begin
            if (!pwrite)
            begin
              d.prdata = {27'h0, curNum};
            end
          end
          `VIC_OFS_IPR:
          begin
            if (!pwrite)
            begin
              d.prdata = pending;
            end
          end
          `VIC_OFS_IMR:
          begin
            if (!pwrite)
            begin
              d.prdata = q.mask;
            end
          end
          `VIC_OFS_CISR:
          begin
            if (!pwrite)
            begin
              d.prdata = {30'h0, q.fastN, q.normalN};
            end
          end
          `VIC_OFS_IECR:
          begin
            if (pwrite)
            begin
              d.mask = q.mask | pwdata;
            end
          end
          `VIC_OFS_IDCR:
          begin
            if (pwrite)
            begin
              d.mask = q.mask & ~pwdata;
            end
          end
          `VIC_OFS_ICCR:
          begin
            if (pwrite)
            begin
              clrCmd = pwdata;
            end
          end
          `VIC_OFS_ISCR:
          begin
            if (pwrite)
            begin
              setCmd = pwdata;
            end
          end
          `VIC_OFS_EOICR:
          begin
            if (pwrite && curValid)
            begin
              d.sp = q.sp - 4'h1;
            end
          end
          `VIC_OFS_GMASK:
          begin
            if (pwrite)
            begin
              d.gmask = pwdata[`VIC_GMASK_BIT];
            end
            else
            begin
              d.prdata[`VIC_GMASK_BIT] = q.gmask;
            end
          end
          `VIC_OFS_FFR:
          begin
            if (pwrite)
            begin
              d.ffr = pwdata & ~32'h0000_0001;
            end
            else
            begin
              d.prdata = q.ffr;
            end
          end
          default: d.pslverr = 1'b1;
        endcase
      end
    end
    irqReq = higher && !ivrRead;
    fiqReq = |(pending & q.mask & (q.ffr | 32'h0000_0001));
    d.normalN = !(irqReq && !q.gmask);
    d.fastN = !(fiqReq && !q.gmask);
    d.wake = irqReq || fiqReq;
  end

  // ----------------------------------------
  // registers, free-running clock
  // ----------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      q <= '0;
      q.normalN <= 1'b1;
      q.fastN <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  // ----------------------------------------
  // outputs straight from flops
  // ----------------------------------------
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign normalRequestN = q.normalN;
  assign fastRequestN = q.fastN;
  assign wake = q.wake;
endmodule // vic_source_control
`default_nettype wire

// [vic_source_control_pad.sv]
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// [core_model.sv]
`timescale 1ns/10ps
`default_nettype none
module core_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic normalRequestN,
  input wire logic fastRequestN,
  input wire logic wake,
  output logic [7:0] wakes
);
  logic idle_q;
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      idle_q <= 1'b1;
      wakes <= 8'h00;
    end
    else if (idle_q && wake)
    begin
      idle_q <= 1'b0;
      wakes <= wakes + 8'h01;
    end
    else if (normalRequestN && fastRequestN)
      idle_q <= 1'b1;
  end
endmodule // core_model
`default_nettype wire

// [vic_source_control_checker.sv]
`timescale 1ns/10ps
`default_nettype none
module vic_source_control_checker (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic normalRequestN,
  input wire logic fastRequestN,
  input wire logic wake
);
  logic tk, rd;
  logic gm_q;
  logic [31:0] mk_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  assign tk = psel && penable && !pready;
  assign rd = tk && !pwrite;
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      mk_q <= 32'h0;
      gm_q <= 1'b0;
    end
    else if (tk && pwrite)
    begin
      if (paddr == 12'h120)
        mk_q <= mk_q | pwdata;
      if (paddr == 12'h124)
        mk_q <= mk_q & ~pwdata;
      if (paddr == 12'h138)
        gm_q <= pwdata[1];
    end
  end
  property p_ans;
    tk |=> pready ##1 !pready;
  endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_wake;
    !normalRequestN || !fastRequestN |-> wake;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  property p_gm;
    gm_q && $past(gm_q) |-> normalRequestN && fastRequestN;
  endproperty
  a_gm: assert property (p_gm) else $error("line under mask");
  property p_mask;
    rd && paddr == 12'h110 |=> prdata == $past(mk_q);
  endproperty
  a_mask: assert property (p_mask) else $error("bad mask");
  property p_fvr;
    rd && paddr == 12'h104 |=> prdata == 32'h0;
  endproperty
  a_fvr: assert property (p_fvr) else $error("bad fast read");
  property p_ivr;
    rd && paddr == 12'h100 |=> prdata < 32'h20 || prdata == 32'hff;
  endproperty
  a_ivr: assert property (p_ivr) else $error("bad number");
  property p_cis;
    rd && paddr == 12'h114 |=> prdata[1:0] == {$past(fastRequestN), $past(normalRequestN)};
  endproperty
  a_cis: assert property (p_cis) else $error("bad line image");
  property p_rel;
    rd && paddr == 12'h100 |=> normalRequestN;
  endproperty
  a_rel: assert property (p_rel) else $error("line kept");
endmodule // vic_source_control_checker
bind vic_source_control vic_source_control_checker chk_i (.clk_sys(clk_sys), .rst(rst), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .normalRequestN(normalRequestN), .fastRequestN(fastRequestN), .wake(wake));
`default_nettype wire

// [vic_source_control_bench.sv]
`timescale 1ns/10ps
`default_nettype none
module vic_source_control_bench;
  logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pin = 1;
  logic pready, pslverr, er, normalRequestN, fastRequestN, wake;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, lf = 32'h11, m = 0;
  logic [3:0] system_source = 0;
  logic [31:2] per = 0;
  logic [7:0] wakes;
  logic [2:0] live, pr [3];
  int errorCnt = 0, samplesChecked = 0, b, srcs [3] = '{3, 9, 20};
  vic_source_control dut (.clk_sys(clk_sys), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fastRequestPin(pin), .systemSource(system_source), .peripheralSource(per),
    .normalRequestN(normalRequestN), .fastRequestN(fastRequestN), .wake(wake));
  core_model core (.clk_sys(clk_sys), .rst(rst), .normalRequestN(normalRequestN),
    .fastRequestN(fastRequestN), .wake(wake), .wakes(wakes));
  initial forever #5 clk_sys = ~clk_sys;
  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic int win(input logic [2:0] l);
    win = 0;
    for (int i = 2; i >= 0; i--)
      if (l[i] && (!l[win] || pr[i] >= pr[win]))
        win = i;
  endfunction
  function automatic logic [31:0] pend(input logic [2:0] l);
    pend = 32'h0200_0000;
    for (int i = 0; i < 3; i++)
      if (l[i])
        pend[srcs[i]] = 1'b1;
  endfunction
  task automatic report_and_stop;
    $display("checked %0d mismatches %0d", samplesChecked, errorCnt);
    if (errorCnt == 0 && samplesChecked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samplesChecked++;
    if (s !== e)
    begin
      errorCnt++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1 && n < 20);
    if (n >= 20)
    begin
      chk(0, 1);
      report_and_stop;
    end
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wt(input logic f);
    int n;
    n = 0;
    while ((f ? fastRequestN : normalRequestN) !== 0 && n < 50)
    begin
      @(posedge clk_sys);
      n++;
    end
    chk(32'(n < 50), 1);
    if (n >= 50)
      report_and_stop;
  endtask
  initial
  begin
    repeat (20) @(posedge clk_sys);
    rst <= 0;
    bus(0, 12'h114, 0);
    chk(rd, 32'h3);
    for (int i = 0; i < 4; i++)
    begin
      lf = nx(lf);
      bus(1, 12'h120, lf);
      m |= lf;
      lf = nx(lf);
      bus(1, 12'h124, lf);
      m &= ~lf;
      bus(0, 12'h110, 0);
      chk(rd, m);
    end
    bus(1, 12'h124, 32'hffff_ffff);
    bus(1, 12'h1f0, 32'hffff_ffff);
    chk(32'(er), 1);
    bus(0, 12'h110, 0);
    chk(rd, 0);
    $display("mask test done");
    for (int r = 0; r < 2; r++)
    begin
      bus(1, 12'h064, 32'h27);
      bus(1, 12'h030, 32'h0);
      for (int i = 0; i < 3; i++)
      begin
        lf = nx(lf);
        pr[i] = r ? lf[2:0] : 3'h5;
        bus(1, 12'(4 * srcs[i]), 32'h20 | 32'(pr[i]));
      end
      bus(1, 12'h12c, 32'h0210_1208);
      bus(1, 12'h120, 32'h0010_0208);
      bus(0, 12'h10c, 0);
      chk(rd, pend(3'h7));
      live = 3'h7;
      for (int k = 0; k < 3; k++)
      begin
        b = win(live);
        wt(0);
        bus(0, 12'h100, 0);
        chk(rd, srcs[b]);
        bus(0, 12'h108, 0);
        chk(rd, srcs[b]);
        bus(1, 12'h130, 0);
        live[b] = 0;
        bus(0, 12'h10c, 0);
        chk(rd, pend(live));
      end
      bus(0, 12'h100, 0);
      chk(rd, 32'hff);
      bus(1, 12'h128, 32'h0200_0000);
    end
    $display("priority test done");
    system_source <= lf[3:0] | 4'h1;
    @(posedge clk_sys);
    bus(0, 12'h10c, 0);
    chk(rd, 32'h2);
    system_source <= 0;
    bus(1, 12'h000, 32'h40);
    bus(1, 12'h120, 32'h1);
    wt(1);
    bus(0, 12'h114, 0);
    chk(rd, 32'h1);
    bus(1, 12'h138, 32'h2);
    bus(0, 12'h114, 0);
    chk(rd, 32'h3);
    chk(32'(wake), 1);
    bus(1, 12'h138, 0);
    bus(1, 12'h000, 32'h60);
    pin <= 0;
    repeat (4) @(posedge clk_sys);
    pin <= 1;
    wt(1);
    bus(0, 12'h104, 0);
    bus(0, 12'h114, 0);
    chk(rd, 32'h3);
    chk(32'(wakes != 0), 1);
    $display("fast test done");
    bus(1, 12'h124, 32'h1);
    bus(1, 12'h140, 32'h201);
    bus(0, 12'h140, 0);
    chk(rd, 32'h200);
    bus(1, 12'h12c, 32'h200);
    wt(1);
    bus(0, 12'h100, 0);
    chk(rd, 32'hff);
    bus(0, 12'h10c, 0);
    chk(rd, 32'h200);
    bus(0, 12'h114, 0);
    chk(rd, 32'h1);
    bus(1, 12'h128, 32'h200);
    $display("forcing test done");
    report_and_stop;
  end
endmodule // vic_source_control_bench
`default_nettype wire
